// *** logic/epm_loader.v ***
// PM capability, PM data and port-2 PHY tail loader from EEPROM words into per-port config fields
`timescale 1ns/1ns
`include "epm_loader_map.vh"

// Contract
// - Port 2: word bit13 to 78h bit11
// - Port 2: word bits15:14 to 8Ch bits9:8
// - Word 50h bit0 to port0 44h bit3
// - PM word bits3:1 to 40h bits24:22
// - Bit4 sets read-only D1 support 40h bit25
// - Bit5 sets read-only D2 support 40h bit26
// - Bits7:6 to 40h bits29:28 PME support
// - Word 51h upper byte to port0 44h data
// - Words 52h/53h load port 1 likewise
// - Word 54h loads port 2 PM fields
// - Word 55h upper byte to port2 data
module epm_loader (
	// Clock and reset
	input wire core_clk,
	input wire rst_n,
	// EEPROM word stream from the serial reader
	input wire ee_word_valid,
	input wire [7:0] ee_word_addr,
	input wire [15:0] ee_word_data,
	input wire ee_load_done,
	input wire ee_load_abort,
	// Per-port config fields, port 0 in the low slice, then the two port-2 PHY tail fields
	output reg [2:0] cfg_no_soft_reset,
	output reg [8:0] cfg_aux_current,
	output reg [2:0] cfg_d1_support,
	output reg [2:0] cfg_d2_support,
	output reg [5:0] cfg_pme_support,
	output reg [23:0] cfg_pm_data,
	output reg cfg_compliance_to_detect_p2,
	output reg [1:0] change_data_count_select,
	// Avalon-MM slave
	input wire [3:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	input wire [3:0] avs_byteenable,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest
);

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	// Port whose PM capability word this is, or 3 for none
	function [1:0] pmc_port;
		input [7:0] a;
		begin
			case (a)
				`EPM_W_PMC_P0: pmc_port = `EPM_P0;
				`EPM_W_PMC_P1: pmc_port = `EPM_P1;
				`EPM_W_PMC_P2: pmc_port = `EPM_P2;
				default: pmc_port = 2'h3;
			endcase
		end
	endfunction

	function [1:0] pmd_port;
		input [7:0] a;
		begin
			case (a)
				`EPM_W_PMD_P0: pmd_port = `EPM_P0;
				`EPM_W_PMD_P1: pmd_port = `EPM_P1;
				`EPM_W_PMD_P2: pmd_port = `EPM_P2;
				default: pmd_port = 2'h3;
			endcase
		end
	endfunction

	// ----------------------------------------
	// Staging and control state
	// ----------------------------------------
	// Words are staged and only committed on a clean finish, so a torn load never half-applies
	reg load_en_ff;
	reg done_ff;
	reg abort_ff;
	reg [10:0] seen_ff;
	reg [2:0] stg_nsr_ff;
	reg [8:0] stg_aux_ff;
	reg [2:0] stg_d1_ff;
	reg [2:0] stg_d2_ff;
	reg [5:0] stg_pme_ff;
	reg [23:0] stg_data_ff;
	reg stg_ctd_ff;
	reg [1:0] stg_cdc_ff;
	reg rd_pending_ff;

	wire [1:0] cport = pmc_port(ee_word_addr);
	wire [1:0] dport = pmd_port(ee_word_addr);
	wire take = ee_word_valid && load_en_ff && !done_ff && !abort_ff;
	wire wr_ctrl = avs_write && avs_address == `EPM_A_CTRL && avs_byteenable[0];
	wire sw_clear = wr_ctrl && avs_writedata[`EPM_B_CLR];

	// ----------------------------------------
	// Per-port staging
	// ----------------------------------------
	genvar gp;
	generate
		for (gp = 0; gp < `EPM_PORTS; gp = gp + 1) begin : g_port
			always @(posedge core_clk) begin
				if (!rst_n || sw_clear) begin
					stg_nsr_ff[gp] <= `EPM_RST_NSR;
					stg_aux_ff[gp*3 +: 3] <= `EPM_RST_AUX;
					stg_d1_ff[gp] <= `EPM_RST_D1;
					stg_d2_ff[gp] <= `EPM_RST_D2;
					stg_pme_ff[gp*2 +: 2] <= `EPM_RST_PME;
					stg_data_ff[gp*8 +: 8] <= `EPM_RST_DATA;
				end else if (take) begin
					if (cport == gp) begin
						stg_nsr_ff[gp] <= ee_word_data[`EPM_S_NSR];
						stg_aux_ff[gp*3 +: 3] <= ee_word_data[`EPM_S_AUX_HI:`EPM_S_AUX_LO];
						stg_d1_ff[gp] <= ee_word_data[`EPM_S_D1];
						stg_d2_ff[gp] <= ee_word_data[`EPM_S_D2];
						stg_pme_ff[gp*2 +: 2] <= ee_word_data[`EPM_S_PME_HI:`EPM_S_PME_LO];
					end
					if (dport == gp) begin
						stg_data_ff[gp*8 +: 8] <= ee_word_data[`EPM_S_DATA_HI:`EPM_S_DATA_LO];
					end
				end
			end
		end
	endgenerate

	always @(posedge core_clk) begin
		if (!rst_n || sw_clear) begin
			stg_ctd_ff <= `EPM_RST_CTD;
			stg_cdc_ff <= `EPM_RST_CDC;
		end else if (take && ee_word_addr == `EPM_W_PHY_P2) begin
			stg_ctd_ff <= ee_word_data[`EPM_S_CTD];
			stg_cdc_ff <= ee_word_data[`EPM_S_CDC_HI:`EPM_S_CDC_LO];
		end
	end

	// ----------------------------------------
	// Load sequencing and commit
	// ----------------------------------------
	wire commit = ee_load_done && load_en_ff && !done_ff && !abort_ff;
	wire [10:0] seen_bit = (ee_word_addr == `EPM_W_PHY_P2) ? 11'h001 :
		(cport != 2'h3) ? (11'h002 << cport) :
		(dport != 2'h3) ? (11'h010 << dport) : 11'h000;

	always @(posedge core_clk) begin
		if (!rst_n) begin
			load_en_ff <= 1'h1;
			done_ff <= 1'h0;
			abort_ff <= 1'h0;
			seen_ff <= 11'h000;
		end else begin
			if (wr_ctrl) begin
				load_en_ff <= avs_writedata[`EPM_B_EN];
			end
			// A load event beats a same-cycle software clear
			if (commit) begin
				done_ff <= 1'h1;
			end else if (sw_clear) begin
				done_ff <= 1'h0;
			end
			if (ee_load_abort && load_en_ff && !done_ff) begin
				abort_ff <= 1'h1;
			end else if (sw_clear) begin
				abort_ff <= 1'h0;
			end
			if (take) begin
				seen_ff <= seen_ff | seen_bit;
			end else if (sw_clear) begin
				seen_ff <= 11'h000;
			end
		end
	end

	// Live fields hold defaults until a completed load commits the staging
	always @(posedge core_clk) begin
		if (!rst_n) begin
			cfg_no_soft_reset <= {`EPM_PORTS{`EPM_RST_NSR}};
			cfg_aux_current <= {`EPM_PORTS{`EPM_RST_AUX}};
			cfg_d1_support <= {`EPM_PORTS{`EPM_RST_D1}};
			cfg_d2_support <= {`EPM_PORTS{`EPM_RST_D2}};
			cfg_pme_support <= {`EPM_PORTS{`EPM_RST_PME}};
			cfg_pm_data <= {`EPM_PORTS{`EPM_RST_DATA}};
			cfg_compliance_to_detect_p2 <= `EPM_RST_CTD;
			change_data_count_select <= `EPM_RST_CDC;
		end else if (commit) begin
			cfg_no_soft_reset <= stg_nsr_ff;
			cfg_aux_current <= stg_aux_ff;
			cfg_d1_support <= stg_d1_ff;
			cfg_d2_support <= stg_d2_ff;
			cfg_pme_support <= stg_pme_ff;
			cfg_pm_data <= stg_data_ff;
			cfg_compliance_to_detect_p2 <= stg_ctd_ff;
			change_data_count_select <= stg_cdc_ff;
		end
	end

	// ----------------------------------------
	// Avalon-MM slave
	// ----------------------------------------
	// Reads answer one cycle late; config images are read-only, writes there are dropped
	assign avs_waitrequest = avs_read && !rd_pending_ff;

	// Images come in as arguments so that always @* wakes on every field change
	function [31:0] pmc_word;
		input [1:0] p;
		input [8:0] aux;
		input [2:0] d1;
		input [2:0] d2;
		input [5:0] pme;
		begin
			pmc_word = 32'h00000000;
			pmc_word[`EPM_T_AUX_HI:`EPM_T_AUX_LO] = aux[p*3 +: 3];
			pmc_word[`EPM_T_D1] = d1[p];
			pmc_word[`EPM_T_D2] = d2[p];
			pmc_word[`EPM_T_PME_HI:`EPM_T_PME_LO] = pme[p*2 +: 2];
		end
	endfunction

	function [31:0] pmcsr_word;
		input [1:0] p;
		input [2:0] nsr;
		input [23:0] data;
		begin
			pmcsr_word = 32'h00000000;
			pmcsr_word[`EPM_T_NSR] = nsr[p];
			pmcsr_word[`EPM_T_DATA_HI:`EPM_T_DATA_LO] = data[p*8 +: 8];
		end
	endfunction

	reg [31:0] nxt_rdata;
	always @* begin
		nxt_rdata = 32'h00000000;
		case (avs_address)
			`EPM_A_CTRL: nxt_rdata[`EPM_B_EN] = load_en_ff;
			`EPM_A_STAT: nxt_rdata = {18'h0, seen_ff, abort_ff, abort_ff | done_ff, done_ff};
			`EPM_A_PMC0: nxt_rdata = pmc_word(`EPM_P0, cfg_aux_current, cfg_d1_support, cfg_d2_support,
				cfg_pme_support);
			`EPM_A_PMC1: nxt_rdata = pmc_word(`EPM_P1, cfg_aux_current, cfg_d1_support, cfg_d2_support,
				cfg_pme_support);
			`EPM_A_PMC2: nxt_rdata = pmc_word(`EPM_P2, cfg_aux_current, cfg_d1_support, cfg_d2_support,
				cfg_pme_support);
			`EPM_A_PMCSR0: nxt_rdata = pmcsr_word(`EPM_P0, cfg_no_soft_reset, cfg_pm_data);
			`EPM_A_PMCSR1: nxt_rdata = pmcsr_word(`EPM_P1, cfg_no_soft_reset, cfg_pm_data);
			`EPM_A_PMCSR2: nxt_rdata = pmcsr_word(`EPM_P2, cfg_no_soft_reset, cfg_pm_data);
			`EPM_A_LINK2: nxt_rdata[`EPM_T_CTD] = cfg_compliance_to_detect_p2;
			`EPM_A_CDC2: nxt_rdata[`EPM_T_CDC_HI:`EPM_T_CDC_LO] = change_data_count_select;
			default: nxt_rdata = 32'h00000000;
		endcase
	end

	always @(posedge core_clk) begin
		if (!rst_n) begin
			rd_pending_ff <= 1'h0;
			avs_readdata <= 32'h00000000;
		end else begin
			rd_pending_ff <= avs_read && !rd_pending_ff;
			if (avs_read && !rd_pending_ff) begin
				avs_readdata <= nxt_rdata;
			end
		end
	end

endmodule // epm_loader

// *** logic/epm_loader_map.vh ***
// Word addresses, config targets, field positions and reset values for the PM config loader
`ifndef EPM_LOADER_MAP_VH
`define EPM_LOADER_MAP_VH

// ----------------------------------------
// EEPROM word addresses
// ----------------------------------------
`define EPM_W_PHY_P2 8'h44
`define EPM_W_PMC_P0 8'h50
`define EPM_W_PMD_P0 8'h51
`define EPM_W_PMC_P1 8'h52
`define EPM_W_PMD_P1 8'h53
`define EPM_W_PMC_P2 8'h54
`define EPM_W_PMD_P2 8'h55

// ----------------------------------------
// EEPROM word source fields
// ----------------------------------------
`define EPM_S_NSR 0
`define EPM_S_AUX_HI 3
`define EPM_S_AUX_LO 1
`define EPM_S_D1 4
`define EPM_S_D2 5
`define EPM_S_PME_HI 7
`define EPM_S_PME_LO 6
`define EPM_S_DATA_HI 15
`define EPM_S_DATA_LO 8
`define EPM_S_CTD 13
`define EPM_S_CDC_HI 15
`define EPM_S_CDC_LO 14

// ----------------------------------------
// Config space offsets (byte addresses)
// ----------------------------------------
`define EPM_O_PMC 12'h040
`define EPM_O_PMCSR 12'h044
`define EPM_O_LINK 12'h078
`define EPM_O_CDC 12'h08C

// ----------------------------------------
// Config target bit positions
// ----------------------------------------
`define EPM_T_NSR 3
`define EPM_T_AUX_HI 24
`define EPM_T_AUX_LO 22
`define EPM_T_D1 25
`define EPM_T_D2 26
`define EPM_T_PME_HI 29
`define EPM_T_PME_LO 28
`define EPM_T_DATA_HI 31
`define EPM_T_DATA_LO 24
`define EPM_T_CTD 11
`define EPM_T_CDC_HI 9
`define EPM_T_CDC_LO 8

// ----------------------------------------
// Reset defaults
// ----------------------------------------
`define EPM_RST_NSR 1'h0
`define EPM_RST_AUX 3'h0
`define EPM_RST_D1 1'h0
`define EPM_RST_D2 1'h0
`define EPM_RST_PME 2'h0
`define EPM_RST_DATA 8'h00
`define EPM_RST_CTD 1'h0
`define EPM_RST_CDC 2'h0

// ----------------------------------------
// Avalon register map (word index = address)
// ----------------------------------------
`define EPM_A_CTRL 4'h0
`define EPM_A_STAT 4'h1
`define EPM_A_PMC0 4'h2
`define EPM_A_PMC1 4'h3
`define EPM_A_PMC2 4'h4
`define EPM_A_PMCSR0 4'h5
`define EPM_A_PMCSR1 4'h6
`define EPM_A_PMCSR2 4'h7
`define EPM_A_LINK2 4'h8
`define EPM_A_CDC2 4'h9
`define EPM_B_EN 0
`define EPM_B_CLR 1
`define EPM_B_DONE 0
`define EPM_B_ABORT 1
`define EPM_B_SEEN 2
`define EPM_PORTS 3
`define EPM_NPORT_W 2
`define EPM_P0 2'h0
`define EPM_P1 2'h1
`define EPM_P2 2'h2

`endif

// *** tb/epm_loader_asserts.sv ***
// Port checker for the PM config loader
`timescale 1ns/1ns
module epm_loader_asserts (
	// Clock, reset and EEPROM stream
	input logic core_clk, rst_n, ee_word_valid, ee_load_done, ee_load_abort,
	input logic [7:0] ee_word_addr,
	input logic [15:0] ee_word_data,
	// Config fields
	input logic [2:0] cfg_no_soft_reset, cfg_d1_support, cfg_d2_support,
	input logic [8:0] cfg_aux_current,
	input logic [5:0] cfg_pme_support,
	input logic [23:0] cfg_pm_data,
	input logic cfg_compliance_to_detect_p2,
	input logic [1:0] change_data_count_select,
	// Avalon slave
	input logic [3:0] avs_address, avs_byteenable,
	input logic avs_read, avs_write, avs_waitrequest,
	input logic [31:0] avs_writedata, avs_readdata
);
	// ----------------------------------------
	// Shadow of staged words, 0 = 44h, 1..6 = 50h..55h
	// ----------------------------------------
	logic [15:0] w_ff [0:6];
	logic fin_ff, en_ff, cmt_ff;
	wire ctl = avs_write && avs_address == 4'h0 && avs_byteenable[0];
	wire clr = ctl && avs_writedata[1];
	wire hit = ee_word_addr == 8'h44 || (ee_word_addr > 8'h4F && ee_word_addr < 8'h56);
	wire [7:0] idx = ee_word_addr == 8'h44 ? 8'h00 : ee_word_addr - 8'h4F;
	always_ff @(posedge core_clk) begin
		cmt_ff <= rst_n && en_ff && ee_load_done && !ee_load_abort && !fin_ff && !clr;
		en_ff <= !rst_n ? 1'b1 : ctl ? avs_writedata[0] : en_ff;
		if (!rst_n || clr) begin
			fin_ff <= 1'b0;
			for (int k = 0; k < 7; k++) w_ff[k] <= 16'h0000;
		end else begin
			if (ee_load_done || ee_load_abort) fin_ff <= 1'b1;
			if (ee_word_valid && hit && en_ff && !fin_ff) w_ff[idx[2:0]] <= ee_word_data;
		end
	end
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_n);
	a_nsr_map: assert property (cmt_ff |->
		cfg_no_soft_reset == {w_ff[5][0], w_ff[3][0], w_ff[1][0]}) else $error("no soft reset field wrong");
	a_aux_map: assert property (cmt_ff |->
		cfg_aux_current == {w_ff[5][3:1], w_ff[3][3:1], w_ff[1][3:1]}) else $error("aux current field wrong");
	a_dstate_map: assert property (cmt_ff |-> {cfg_d2_support, cfg_d1_support} ==
		{w_ff[5][5], w_ff[3][5], w_ff[1][5], w_ff[5][4], w_ff[3][4], w_ff[1][4]}) else $error("d1 d2 field wrong");
	a_pme_map: assert property (cmt_ff |->
		cfg_pme_support == {w_ff[5][7:6], w_ff[3][7:6], w_ff[1][7:6]}) else $error("pme field wrong");
	a_data_map: assert property (cmt_ff |->
		cfg_pm_data == {w_ff[6][15:8], w_ff[4][15:8], w_ff[2][15:8]}) else $error("pm data byte wrong");
	a_phy_tail: assert property (cmt_ff |->
		{change_data_count_select, cfg_compliance_to_detect_p2} == w_ff[0][15:13]) else $error("port 2 phy tail wrong");
	// A reset reloads defaults, so the edge right after one is not a move
	a_hold_live: assert property ($past(rst_n) && !$past(ee_load_done) |->
		$stable(cfg_pm_data) && $stable(cfg_aux_current) && $stable(cfg_no_soft_reset) &&
		$stable(change_data_count_select)) else $error("live field moved without commit");
	a_read_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
		else $error("read wait state wrong");
	c_commit: cover property (cmt_ff);
	c_abort: cover property (ee_load_abort && !fin_ff);
	c_read: cover property ($rose(avs_read));
endmodule // epm_loader_asserts

bind epm_loader epm_loader_asserts u_chk (.*);

// *** tb/epm_ee_model.sv ***
// Behavioural EEPROM reader streaming words 44h, 50h..55h
`timescale 1ns/1ns
module epm_ee_model (
	// Clock and control
	input logic core_clk, go, fail, slow,
	// Word stream
	output logic ee_word_valid, ee_load_done, ee_load_abort,
	output logic [7:0] ee_word_addr,
	output logic [15:0] ee_word_data
);
	// ----------------------------------------
	// Stream engine
	// ----------------------------------------
	logic [15:0] mem [0:6];
	logic [3:0] k_ff = 4'h8;
	logic ph_ff = 1'b0;
	wire snd = !go && k_ff < 4'h7 && (!slow || ph_ff);
	initial {ee_word_valid, ee_load_done, ee_load_abort, ee_word_addr, ee_word_data} = '0;
	always @(posedge core_clk) begin
		ph_ff <= ~ph_ff;
		ee_word_valid <= snd;
		ee_load_done <= !go && k_ff == 4'h7 && !fail;
		ee_load_abort <= !go && k_ff == 4'h7 && fail;
		ee_word_addr <= k_ff == 4'h0 ? 8'h44 : 8'h4F + {4'h0, k_ff};
		// Idle line flips so a stale word never looks valid
		ee_word_data <= snd ? mem[k_ff[2:0]] : ~ee_word_data;
		k_ff <= go ? 4'h0 : snd || k_ff == 4'h7 ? k_ff + 4'h1 : k_ff;
	end
endmodule // epm_ee_model

// *** tb/tb_top.sv ***
// Self-checking bench for the PM config loader
`timescale 1ns/1ns
`include "epm_loader_map.vh"
module tb_top;
	logic core_clk = 1'b0, rst_n = 1'b0, go = 1'b0, fail = 1'b0, slow = 1'b0;
	logic avs_read = 1'b0, avs_write = 1'b0;
	logic [3:0] avs_address = 4'h0, avs_byteenable = 4'hF;
	logic [31:0] avs_writedata = 32'h0, rd_d;
	logic [15:0] lf = 16'h0011;
	logic [15:0] e [0:6];
	wire ee_word_valid, ee_load_done, ee_load_abort, avs_waitrequest, cfg_compliance_to_detect_p2;
	wire [7:0] ee_word_addr;
	wire [15:0] ee_word_data;
	wire [2:0] cfg_no_soft_reset, cfg_d1_support, cfg_d2_support;
	wire [8:0] cfg_aux_current;
	wire [5:0] cfg_pme_support;
	wire [23:0] cfg_pm_data;
	wire [1:0] change_data_count_select;
	wire [31:0] avs_readdata;
	int n_errors = 0, num_checks = 0, cyc = 0;
	epm_loader dut (.*);
	epm_ee_model ee (.*);
	// ----------------------------------------
	// Clock, timeout and helpers
	// ----------------------------------------
	initial forever #5 core_clk = ~core_clk;
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			n_errors = n_errors + 1;
			close_out;
		end
	end
	function automatic logic [15:0] nx(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	function automatic logic [31:0] pmc(input logic [15:0] w);
		return {2'h0, w[7:6], 1'h0, w[5:4], w[3:1], 22'h0};
	endfunction
	task close_out;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			n_errors++;
			$display("BAD %0t got %h exp %h", $time, g, x);
		end
	endtask
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_read <= !w;
		avs_write <= w;
		avs_address <= a;
		avs_writedata <= d;
		do @(posedge core_clk); while (avs_waitrequest !== 1'b0);
		rd_d = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task load(input logic f, input logic ones, input logic keep);
		for (int i = 0; i < 7; i++) begin
			if (!ones) lf = nx(lf);
			ee.mem[i] = ones ? 16'hFFFF : lf;
			if (!f && !keep) e[i] = ee.mem[i];
		end
		@(posedge core_clk);
		go <= 1'b1;
		fail <= f;
		@(posedge core_clk);
		go <= 1'b0;
		repeat (20) @(posedge core_clk);
	endtask
	task check_all;
		for (logic [3:0] p = 0; p < 3; p++) begin
			chk({cfg_pme_support[2*p+:2], cfg_d2_support[p], cfg_d1_support[p], cfg_aux_current[3*p+:3],
				cfg_no_soft_reset[p]}, e[2*p+1][7:0]);
			chk(cfg_pm_data[8*p+:8], e[2*p+2][15:8]);
			// Image write must be ignored: the capability bits are read-only
			bus(1'b1, `EPM_A_PMC0 + p, 32'hFFFFFFFF);
			bus(1'b0, `EPM_A_PMC0 + p, 32'h0);
			chk(rd_d, pmc(e[2*p+1]));
			bus(1'b0, `EPM_A_PMCSR0 + p, 32'h0);
			chk(rd_d, {e[2*p+2][15:8], 20'h0, e[2*p+1][0], 3'h0});
		end
		chk({change_data_count_select, cfg_compliance_to_detect_p2}, e[0][15:13]);
		bus(1'b0, `EPM_A_LINK2, 32'h0);
		chk(rd_d, {20'h0, e[0][13], 11'h0});
		bus(1'b0, `EPM_A_CDC2, 32'h0);
		chk(rd_d, {22'h0, e[0][15:14], 8'h0});
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		for (int i = 0; i < 7; i++) e[i] = 16'h0000;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		check_all;
		load(1'b0, 1'b1, 1'b0);
		check_all;
		for (int r = 0; r < 4; r++) begin
			bus(1'b1, `EPM_A_CTRL, 32'h3);
			slow <= r[0];
			load(r == 3, 1'b0, 1'b0);
			check_all;
			bus(1'b0, `EPM_A_STAT, 32'h0);
			chk(rd_d, r == 3 ? 32'h3FE : 32'h3FB);
		end
		// Disarmed loader ignores a whole load, done pulse included
		bus(1'b1, `EPM_A_CTRL, 32'h2);
		load(1'b0, 1'b0, 1'b1);
		check_all;
		bus(1'b0, `EPM_A_STAT, 32'h0);
		chk(rd_d, 32'h0);
		// Control write without its byte lane must not rearm
		avs_byteenable <= 4'h0;
		bus(1'b1, `EPM_A_CTRL, 32'h1);
		avs_byteenable <= 4'hF;
		bus(1'b0, `EPM_A_CTRL, 32'h0);
		chk(rd_d, 32'h0);
		bus(1'b0, 4'hF, 32'h0);
		chk(rd_d, 32'h0);
		@(posedge core_clk);
		rst_n <= 1'b0;
		repeat (2) @(posedge core_clk);
		rst_n <= 1'b1;
		for (int i = 0; i < 7; i++) e[i] = 16'h0000;
		check_all;
		bus(1'b0, `EPM_A_CTRL, 32'h0);
		chk(rd_d, 32'h1);
		close_out;
	end
endmodule // tb_top
